// *** design/tcp_timer.sv ***
// Chosen here: the plain strobed port and the register addresses.
`timescale 1ns/1ps

// Operation
// - free-running, valid input-A edge copies count into register B, raises irq_b.
// - input-A valid edge selected by prescaler config bits 4 and 5.
// - input-B valid edge selected by prescaler config bits 6 and 7.
// - inputs sampled on count clock; level must be seen twice before capture.
// - input-B valid edge copies count into register A, raises irq_a.
// - in two-register mode, opposite input-A edge captures into register A.
// - input-A both-edges selection blocks register-A capture in two-register and restart.
// - capture source bit set: input-B edge raises irq_a without capturing.
// - restart mode: input-A edge captures into B, then clears counter.
// - device sets overflow flag on wrap; software ignores it while measuring.
// - output enable and toggle bits set: pin inverts on each register-A match, every register-A-plus-one counts in clear-on-match run mode.
// - pulse output drives width from register B, period from register A.
// - pulse period is A plus one counts, active time B plus one counts.
// - counter runs while run bits nonzero, stops when both are zero.
module tcp_timer (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// register port
	input  wire logic [2:0]  addr_i,
	input  wire logic [15:0] wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic      [15:0] rdata_o,
	// pins
	input  wire logic        capture_input_a_i,
	input  wire logic        capture_input_b_i,
	output logic             timer_output_pin_o,
	// event requests
	output logic             irq_a_o,
	output logic             irq_b_o
);

	logic [15:0]         cnt_ff;
	logic [15:0]         cc_a_ff;
	logic [15:0]         cc_b_ff;
	tcp_pkg::tcp_run_e   run_ff;
	tcp_pkg::tcp_ccctl_s ccctl_ff;
	tcp_pkg::tcp_presc_s presc_ff;
	tcp_pkg::tcp_outctl_s outctl_ff;
	logic                ovf_ff;
	logic [7:0]          pre_ff;
	logic                tick;
	logic [1:0]          sync_a_ff;
	logic [1:0]          sync_b_ff;
	logic [1:0]          smp_a_ff;
	logic [1:0]          smp_b_ff;
	logic                filt_a_ff;
	logic                filt_b_ff;
	logic                out_ff;
	logic                running;
	logic                rise_a;
	logic                fall_a;
	logic                rise_b;
	logic                fall_b;
	logic                edge_a_ev;
	logic                edge_b_ev;
	logic                opp_a_ev;
	logic                cap_b_ev;
	logic                cap_a_ev;
	logic                irqa_ev;
	logic                match_a;
	logic                match_b;
	logic                clr_match;
	logic                restart_ev;
	logic                wrap_ev;
	logic                ppg_mode;

	assign running = (run_ff != tcp_pkg::TCP_RUN_STOP);

	// count clock prescaler: full rate, /4, /256
	always_ff @(posedge clk_i) begin
		if (rst_i || !running) begin
			pre_ff <= 8'h00;
		end else begin
			pre_ff <= pre_ff + 8'h01;
		end
	end

	always_comb begin
		case (presc_ff.clk_sel)
			2'b01:   tick = running && (pre_ff[1:0] == tcp_pkg::DIV4_LAST[1:0]);
			2'b10:   tick = running && (pre_ff == tcp_pkg::DIV256_LAST);
			default: tick = running;
		endcase
	end

	// pin synchronisers, two flip-flops each
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync_a_ff <= 2'b00;
			sync_b_ff <= 2'b00;
		end else begin
			sync_a_ff <= {sync_a_ff[0], capture_input_a_i};
			sync_b_ff <= {sync_b_ff[0], capture_input_b_i};
		end
	end

	// noise filter: level accepted after two equal count-clock samples
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			smp_a_ff  <= 2'b00;
			smp_b_ff  <= 2'b00;
			filt_a_ff <= 1'b0;
			filt_b_ff <= 1'b0;
		end else if (tick) begin
			smp_a_ff <= {smp_a_ff[0], sync_a_ff[1]};
			smp_b_ff <= {smp_b_ff[0], sync_b_ff[1]};
			if (smp_a_ff[0] == smp_a_ff[1]) begin
				filt_a_ff <= smp_a_ff[1];
			end
			if (smp_b_ff[0] == smp_b_ff[1]) begin
				filt_b_ff <= smp_b_ff[1];
			end
		end
	end

	// filtered edges, taken only while the counter runs
	assign rise_a = tick && (smp_a_ff[0] == smp_a_ff[1]) && smp_a_ff[1] && !filt_a_ff;
	assign fall_a = tick && (smp_a_ff[0] == smp_a_ff[1]) && !smp_a_ff[1] && filt_a_ff;
	assign rise_b = tick && (smp_b_ff[0] == smp_b_ff[1]) && smp_b_ff[1] && !filt_b_ff;
	assign fall_b = tick && (smp_b_ff[0] == smp_b_ff[1]) && !smp_b_ff[1] && filt_b_ff;

	// valid edge and opposite edge per selection
	always_comb begin
		case (presc_ff.edge_a)
			tcp_pkg::TCP_EDGE_FALL: begin
				edge_a_ev = fall_a;
				opp_a_ev  = rise_a;
			end
			tcp_pkg::TCP_EDGE_RISE: begin
				edge_a_ev = rise_a;
				opp_a_ev  = fall_a;
			end
			tcp_pkg::TCP_EDGE_BOTH: begin
				edge_a_ev = rise_a || fall_a;
				opp_a_ev  = 1'b0;
			end
			default: begin
				edge_a_ev = 1'b0;
				opp_a_ev  = 1'b0;
			end
		endcase
		case (presc_ff.edge_b)
			tcp_pkg::TCP_EDGE_FALL: edge_b_ev = fall_b;
			tcp_pkg::TCP_EDGE_RISE: edge_b_ev = rise_b;
			tcp_pkg::TCP_EDGE_BOTH: edge_b_ev = rise_b || fall_b;
			default:                edge_b_ev = 1'b0;
		endcase
	end

	// capture and compare events
	assign cap_b_ev   = ccctl_ff.b_capture && edge_a_ev;
	assign cap_a_ev   = ccctl_ff.a_capture && (ccctl_ff.capture_source_a_bit ?
		opp_a_ev : edge_b_ev);
	assign irqa_ev    = cap_a_ev || (ccctl_ff.a_capture && edge_b_ev) || match_a;
	assign match_a    = tick && !ccctl_ff.a_capture && (cnt_ff == cc_a_ff);
	assign match_b    = tick && !ccctl_ff.b_capture && (cnt_ff == cc_b_ff);
	assign clr_match  = match_a && (run_ff == tcp_pkg::TCP_RUN_MATCH);
	assign restart_ev = edge_a_ev && (run_ff == tcp_pkg::TCP_RUN_RESTART);
	assign wrap_ev    = tick && (cnt_ff == tcp_pkg::COUNT_MAX) && !clr_match && !restart_ev;
	assign ppg_mode   = outctl_ff.ppg_select && (run_ff == tcp_pkg::TCP_RUN_MATCH);

	// counter
	always_ff @(posedge clk_i) begin
		if (rst_i || !running) begin
			cnt_ff <= 16'h0000;
		end else if (clr_match || restart_ev) begin
			cnt_ff <= 16'h0000;
		end else if (tick) begin
			cnt_ff <= cnt_ff + 16'h0001;
		end
	end

	// overflow flag: wrap sets, write of one clears, set wins
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ovf_ff <= 1'b0;
		end else if (wrap_ev) begin
			ovf_ff <= 1'b1;
		end else if (wr_i && addr_i == tcp_pkg::ADDR_STATUS && wdata_i[tcp_pkg::OVF_POS]) begin
			ovf_ff <= 1'b0;
		end
	end

	// compare/capture registers: hardware capture wins over a software write
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cc_a_ff <= tcp_pkg::CMP_RST;
			cc_b_ff <= tcp_pkg::CMP_RST;
		end else begin
			if (cap_a_ev) begin
				cc_a_ff <= cnt_ff;
			end else if (wr_i && addr_i == tcp_pkg::ADDR_CMP_A) begin
				cc_a_ff <= wdata_i;
			end
			if (cap_b_ev) begin
				cc_b_ff <= cnt_ff;
			end else if (wr_i && addr_i == tcp_pkg::ADDR_CMP_B) begin
				cc_b_ff <= wdata_i;
			end
		end
	end

	// control registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			run_ff    <= tcp_pkg::TCP_RUN_STOP;
			ccctl_ff  <= '0;
			presc_ff  <= '0;
			outctl_ff <= '0;
		end else if (wr_i) begin
			case (addr_i)
				tcp_pkg::ADDR_MODE: begin
					run_ff <= tcp_pkg::tcp_run_e'(
						wdata_i[tcp_pkg::RUN_HI_POS:tcp_pkg::RUN_LO_POS]);
				end
				tcp_pkg::ADDR_CCCTL:  ccctl_ff  <= tcp_pkg::tcp_ccctl_s'(wdata_i[2:0]);
				tcp_pkg::ADDR_PRESC:  presc_ff  <= tcp_pkg::tcp_presc_s'(wdata_i[7:0]);
				tcp_pkg::ADDR_OUTCTL: outctl_ff <= tcp_pkg::tcp_outctl_s'(wdata_i[2:0]);
				default: begin
				end
			endcase
		end
	end

	// event pulses, one cycle each
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_a_o <= 1'b0;
			irq_b_o <= 1'b0;
		end else begin
			irq_a_o <= irqa_ev;
			irq_b_o <= cap_b_ev || match_b;
		end
	end

	// timer output: square wave toggle or programmable pulse
	always_ff @(posedge clk_i) begin
		if (rst_i || !outctl_ff.output_enable_bit) begin
			out_ff <= 1'b0;
		end else if (ppg_mode) begin
			if (clr_match) begin
				out_ff <= 1'b1;
			end else if (match_b) begin
				out_ff <= 1'b0;
			end
		end else if (outctl_ff.toggle_on_match_bit && match_a) begin
			out_ff <= !out_ff;
		end
	end

	assign timer_output_pin_o = out_ff;

	// read data, one cycle after the strobe
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdata_o <= 16'h0000;
		end else if (rd_i) begin
			case (addr_i)
				tcp_pkg::ADDR_COUNT:  rdata_o <= cnt_ff;
				tcp_pkg::ADDR_CMP_A:  rdata_o <= cc_a_ff;
				tcp_pkg::ADDR_CMP_B:  rdata_o <= cc_b_ff;
				tcp_pkg::ADDR_MODE:   rdata_o <= {12'h000, run_ff, 2'b00};
				tcp_pkg::ADDR_CCCTL:  rdata_o <= {13'h0000, ccctl_ff};
				tcp_pkg::ADDR_PRESC:  rdata_o <= {8'h00, presc_ff};
				tcp_pkg::ADDR_OUTCTL: rdata_o <= {13'h0000, outctl_ff};
				default:              rdata_o <= {15'h0000, ovf_ff};
			endcase
		end else begin
			rdata_o <= 16'h0000;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_restart_edge;
		restart_ev && ccctl_ff.b_capture;
	endsequence

	sequence s_cleared_with_capture;
		cnt_ff == 16'h0000 && cc_b_ff == $past(cnt_ff) && irq_b_o;
	endsequence

	a_capture_b_value: assert property (cap_b_ev |=> irq_b_o && cc_b_ff == $past(cnt_ff))
		else $error("register B did not capture the count");
	a_restart_seq: assert property (s_restart_edge |=> s_cleared_with_capture)
		else $error("restart did not capture then clear");
	a_filter_twice: assert property ($changed(filt_a_ff) |-> $past(smp_a_ff[0] == smp_a_ff[1]))
		else $error("input level accepted without two equal samples");
	a_both_no_a: assert property ((presc_ff.edge_a == tcp_pkg::TCP_EDGE_BOTH
		&& ccctl_ff.capture_source_a_bit) |-> !cap_a_ev)
		else $error("register A captured with both edges selected");
	a_ext_irq_a: assert property ((ccctl_ff.a_capture && ccctl_ff.capture_source_a_bit && edge_b_ev
		&& !opp_a_ev && !wr_i) |=> irq_a_o && $stable(cc_a_ff))
		else $error("external event captured or missed its request");
	a_capture_a_b: assert property ((ccctl_ff.a_capture && !ccctl_ff.capture_source_a_bit
		&& edge_b_ev) |=> irq_a_o && cc_a_ff == $past(cnt_ff))
		else $error("input B edge did not capture into register A");
	a_wrap_flag: assert property ((run_ff == tcp_pkg::TCP_RUN_FREE && wrap_ev)
		|=> cnt_ff == 16'h0000 && ovf_ff)
		else $error("counter wrap missing or flag not set");
	a_stop_clear: assert property ((!running ##1 !running) |-> cnt_ff == 16'h0000 [*2])
		else $error("counter moved while stopped");
	a_square_flip: assert property ((outctl_ff.output_enable_bit && !ppg_mode
		&& outctl_ff.toggle_on_match_bit && match_a) |=> out_ff != $past(out_ff))
		else $error("output did not invert on match");
	a_ppg_edges: assert property ((outctl_ff.output_enable_bit && ppg_mode && clr_match)
		|=> out_ff ##0 (cnt_ff == 16'h0000))
		else $error("pulse did not start at period boundary");

	// edge selection and filtering, counting, capture, output disable and pulse fall
	sequence s_ppg_b_match;
		outctl_ff.output_enable_bit && ppg_mode && match_b && !clr_match;
	endsequence

	a_rise_sel_a: assert property ((presc_ff.edge_a == tcp_pkg::TCP_EDGE_RISE)
		|-> (edge_a_ev == rise_a))
		else $error("input A edge does not follow rise selection");
	a_none_sel_b: assert property ((presc_ff.edge_b == tcp_pkg::TCP_EDGE_NONE)
		|-> !edge_b_ev)
		else $error("input B edge taken with none selected");
	a_filter_b: assert property ($changed(filt_b_ff)
		|-> $past(smp_b_ff[0] == smp_b_ff[1]))
		else $error("input B level accepted without two equal samples");
	a_stop_no_edge: assert property (!running |-> !edge_a_ev && !edge_b_ev)
		else $error("edge taken while stopped");
	a_count_step: assert property ((tick && !clr_match && !restart_ev)
		|=> cnt_ff == $past(cnt_ff) + 16'h0001)
		else $error("counter did not step by one");
	a_opp_cap_a: assert property ((ccctl_ff.a_capture && ccctl_ff.capture_source_a_bit
		&& opp_a_ev) |=> irq_a_o && cc_a_ff == $past(cnt_ff))
		else $error("opposite input A edge did not capture into register A");
	a_out_off: assert property (!outctl_ff.output_enable_bit |=> !out_ff)
		else $error("output driven while disabled");
	a_ppg_fall: assert property (s_ppg_b_match |=> !out_ff)
		else $error("pulse did not end at register B match");

endmodule

// *** inc/tcp_pkg.sv ***
package tcp_pkg;

	// register word indices on the plain register port
	localparam logic [2:0] ADDR_COUNT   = 3'h0;
	localparam logic [2:0] ADDR_CMP_A   = 3'h1;
	localparam logic [2:0] ADDR_CMP_B   = 3'h2;
	localparam logic [2:0] ADDR_MODE    = 3'h3;
	localparam logic [2:0] ADDR_CCCTL   = 3'h4;
	localparam logic [2:0] ADDR_PRESC   = 3'h5;
	localparam logic [2:0] ADDR_OUTCTL  = 3'h6;
	localparam logic [2:0] ADDR_STATUS  = 3'h7;

	// field positions
	localparam int RUN_LO_POS   = 2;
	localparam int RUN_HI_POS   = 3;
	localparam int EDGE_A_POS   = 4;
	localparam int EDGE_B_POS   = 6;
	localparam int CLKSEL_POS   = 0;
	localparam int OVF_POS      = 0;

	// reset value and counter limit
	localparam logic [15:0] CMP_RST   = 16'h0000;
	localparam logic [15:0] COUNT_MAX = 16'hFFFF;

	// count clock prescaler ratios, expressed as terminal counts
	localparam logic [7:0] DIV4_LAST   = 8'h03;
	localparam logic [7:0] DIV256_LAST = 8'hFF;

	// run mode (timer_mode_control bits 3:2)
	typedef enum logic [1:0] {
		TCP_RUN_STOP    = 2'b00,
		TCP_RUN_RESTART = 2'b01,
		TCP_RUN_FREE    = 2'b10,
		TCP_RUN_MATCH   = 2'b11
	} tcp_run_e;

	// valid edge selection for a capture input
	typedef enum logic [1:0] {
		TCP_EDGE_FALL = 2'b00,
		TCP_EDGE_RISE = 2'b01,
		TCP_EDGE_NONE = 2'b10,
		TCP_EDGE_BOTH = 2'b11
	} tcp_edge_e;

	// capture_compare_control
	typedef struct packed {
		logic b_capture;
		logic capture_source_a_bit;
		logic a_capture;
	} tcp_ccctl_s;

	// output_control
	typedef struct packed {
		logic ppg_select;
		logic toggle_on_match_bit;
		logic output_enable_bit;
	} tcp_outctl_s;

	// prescaler_edge_config
	typedef struct packed {
		tcp_edge_e edge_b;
		tcp_edge_e edge_a;
		logic [1:0] reserved;
		logic [1:0] clk_sel;
	} tcp_presc_s;

endpackage

// *** verification/tcp_pulse_src.sv ***
`timescale 1ns/1ps

// pulse sources that stand on the two capture pins
module tcp_pulse_src (
	// clock
	input  wire logic clk_i,
	// pins toward the timer
	output logic      cap_a_o,
	output logic      cap_b_o
);
	// both pins are driven only from this side, the timer treats them as inputs
	initial begin
		cap_a_o = 1'b0;
		cap_b_o = 1'b0;
	end

	// change one pin right after an edge, then hold it for n more clock edges before returning
	task automatic drive(input logic sel_b, input logic lvl, input int n);
		@(posedge clk_i);
		if (sel_b) begin
			cap_b_o <= lvl;
		end else begin
			cap_a_o <= lvl;
		end
		repeat (n) @(posedge clk_i);
	endtask
endmodule

// *** verification/tcp_timer_test.sv ***
`timescale 1ns/1ps

module tcp_timer_test;
	typedef struct packed {
		tcp_pkg::tcp_edge_e e;
		logic               r;
		logic               f;
	} tcp_row_s;
	logic        clk_i   = 1'b0;
	logic        rst_i   = 1'b1;
	logic [2:0]  addr_i  = 3'h0;
	logic [15:0] wdata_i = 16'h0000;
	logic        wr_i    = 1'b0;
	logic        rd_i    = 1'b0;
	logic [15:0] rdata_o;
	logic        cap_a;
	logic        cap_b;
	logic        timer_output_pin_o;
	logic        irq_a_o;
	logic        irq_b_o;
	logic        pin_q   = 1'b0;
	logic [15:0] v0;
	logic [15:0] v1;
	int          errors  = 0;
	int          samples_checked = 0;
	int          cyc     = 0;
	int          na      = 0;
	int          nb      = 0;
	int          n0;
	int          q_rise[$];
	int          q_fall[$];
	tcp_row_s    rows[4] = '{'{tcp_pkg::TCP_EDGE_FALL, 1'b0, 1'b1},
		'{tcp_pkg::TCP_EDGE_RISE, 1'b1, 1'b0}, '{tcp_pkg::TCP_EDGE_NONE, 1'b0, 1'b0},
		'{tcp_pkg::TCP_EDGE_BOTH, 1'b1, 1'b1}};

	tcp_timer i_tcp_timer (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .capture_input_a_i(cap_a),
		.capture_input_b_i(cap_b), .timer_output_pin_o(timer_output_pin_o),
		.irq_a_o(irq_a_o), .irq_b_o(irq_b_o));
	tcp_pulse_src i_tcp_pulse_src (.clk_i(clk_i), .cap_a_o(cap_a), .cap_b_o(cap_b));

	always #25 clk_i = ~clk_i;

	// cycle count, event tallies, output edge times and hang limit
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		pin_q <= timer_output_pin_o;
		if (irq_a_o === 1'b1) na <= na + 1;
		if (irq_b_o === 1'b1) nb <= nb + 1;
		if (timer_output_pin_o === 1'b1 && pin_q === 1'b0) q_rise.push_back(cyc);
		if (timer_output_pin_o === 1'b0 && pin_q === 1'b1) q_fall.push_back(cyc);
		if (cyc == 20000) begin
			errors = errors + 1;
			close_out();
		end
	end

	task automatic close_out();
		$display("checks %0d errors %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr(input logic [2:0] a, input logic [15:0] d);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask

	task automatic rd(input logic [2:0] a, output logic [15:0] d);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1 d = rdata_o;
	endtask

	// stop before touching compares, then control, compares, output, clock and mode last
	task automatic cfg(input logic [15:0] cc, a, b, oc, pr, md);
		wr(tcp_pkg::ADDR_MODE, 16'h0000);
		wr(tcp_pkg::ADDR_CCCTL, cc);
		wr(tcp_pkg::ADDR_CMP_A, a);
		wr(tcp_pkg::ADDR_CMP_B, b);
		wr(tcp_pkg::ADDR_OUTCTL, oc);
		wr(tcp_pkg::ADDR_PRESC, pr);
		wr(tcp_pkg::ADDR_MODE, md);
	endtask

	// main sequence
	initial begin
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		for (int i = 0; i < 8; i++) begin
			rd(3'(i), v0);
			cmp("reset register", 16'h0000, v0);
		end
		cmp("pin after reset", 16'h0000, {15'h0000, timer_output_pin_o});
		cfg(16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0008);
		rd(tcp_pkg::ADDR_COUNT, v0);
		rd(tcp_pkg::ADDR_COUNT, v1);
		cmp("count step", v0 + 16'h0002, v1);
		wr(tcp_pkg::ADDR_MODE, 16'h0000);
		rd(tcp_pkg::ADDR_COUNT, v0);
		cmp("stopped count", 16'h0000, v0);
		// edge selection table on input A
		foreach (rows[i]) begin
			cfg(16'h0004, 16'h0000, 16'h0000, 16'h0000, {10'h000, rows[i].e, 4'h0}, 16'h0008);
			n0 = nb;
			i_tcp_pulse_src.drive(1'b0, 1'b1, 12);
			cmp("irq b on rise", 16'(rows[i].r), 16'(nb - n0));
			n0 = nb;
			i_tcp_pulse_src.drive(1'b0, 1'b0, 12);
			cmp("irq b on fall", 16'(rows[i].f), 16'(nb - n0));
		end
		cfg(16'h0004, 16'h0000, 16'h0000, 16'h0000, 16'h0010, 16'h0008);
		rd(tcp_pkg::ADDR_COUNT, v0);
		i_tcp_pulse_src.drive(1'b0, 1'b1, 12);
		rd(tcp_pkg::ADDR_CMP_B, v1);
		cmp("capture window", 16'h0001, 16'(v1 > v0 && v1 - v0 <= 16'h0010));
		i_tcp_pulse_src.drive(1'b0, 1'b0, 12);
		n0 = nb;
		i_tcp_pulse_src.drive(1'b0, 1'b1, 0);
		i_tcp_pulse_src.drive(1'b0, 1'b0, 12);
		cmp("short pulse", 16'h0000, 16'(nb - n0));
		cfg(16'h0004, 16'h0000, 16'h0000, 16'h0000, 16'h0011, 16'h0008);
		n0 = nb;
		i_tcp_pulse_src.drive(1'b0, 1'b1, 3);
		i_tcp_pulse_src.drive(1'b0, 1'b0, 20);
		cmp("slow short pulse", 16'h0000, 16'(nb - n0));
		n0 = nb;
		i_tcp_pulse_src.drive(1'b0, 1'b1, 30);
		cmp("slow clock pulse", 16'h0001, 16'(nb - n0));
		i_tcp_pulse_src.drive(1'b0, 1'b0, 30);
		// input B into register A, then two-register mode
		cfg(16'h0001, 16'h0000, 16'h0000, 16'h0000, 16'h00F0, 16'h0008);
		n0 = na;
		i_tcp_pulse_src.drive(1'b1, 1'b1, 12);
		cmp("irq a from b", 16'h0001, 16'(na - n0));
		rd(tcp_pkg::ADDR_CMP_A, v0);
		cmp("a captured", 16'h0001, 16'(v0 != 16'h0000));
		i_tcp_pulse_src.drive(1'b1, 1'b0, 12);
		cfg(16'h0003, 16'h0000, 16'h0000, 16'h0000, 16'h0070, 16'h0008);
		n0 = na;
		i_tcp_pulse_src.drive(1'b1, 1'b1, 12);
		cmp("irq a only", 16'h0001, 16'(na - n0));
		i_tcp_pulse_src.drive(1'b0, 1'b1, 12);
		i_tcp_pulse_src.drive(1'b0, 1'b0, 12);
		rd(tcp_pkg::ADDR_CMP_A, v0);
		cmp("a not captured", 16'h0000, v0);
		i_tcp_pulse_src.drive(1'b1, 1'b0, 12);
		cfg(16'h0003, 16'h0000, 16'h0000, 16'h0000, 16'h0090, 16'h0008);
		i_tcp_pulse_src.drive(1'b0, 1'b1, 12);
		rd(tcp_pkg::ADDR_CMP_A, v0);
		cmp("a after rise", 16'h0000, v0);
		i_tcp_pulse_src.drive(1'b0, 1'b0, 12);
		rd(tcp_pkg::ADDR_CMP_A, v0);
		cmp("a after fall", 16'h0001, 16'(v0 != 16'h0000));
		// restart on input A edge
		cfg(16'h0004, 16'h0000, 16'h0000, 16'h0000, 16'h0010, 16'h0004);
		i_tcp_pulse_src.drive(1'b0, 1'b0, 40);
		n0 = nb;
		i_tcp_pulse_src.drive(1'b0, 1'b1, 8);
		rd(tcp_pkg::ADDR_COUNT, v0);
		rd(tcp_pkg::ADDR_CMP_B, v1);
		cmp("restart irq", 16'h0001, 16'(nb - n0));
		cmp("restart counts", 16'h0001, 16'(v0 < 16'h0010 && v1 > 16'h0028));
		// square wave and pulse output, register A always loaded nonzero
		cfg(16'h0000, 16'h0004, 16'h0000, 16'h0003, 16'h0000, 16'h000C);
		i_tcp_pulse_src.drive(1'b0, 1'b0, 60);
		cmp("square period", 16'h000A, 16'(q_rise[$] - q_rise[$-1]));
		n0 = q_fall[$] - q_rise[$];
		cmp("square half", 16'h0005, 16'(n0 < 0 ? -n0 : n0));
		cfg(16'h0000, 16'h0009, 16'h0003, 16'h0005, 16'h0000, 16'h000C);
		i_tcp_pulse_src.drive(1'b0, 1'b0, 60);
		cmp("pulse period", 16'h000A, 16'(q_rise[$] - q_rise[$-1]));
		n0 = q_fall[$] > q_rise[$] ? q_rise[$] : q_rise[$-1];
		cmp("pulse high", 16'h0004, 16'(q_fall[$] - n0));
		close_out();
	end
endmodule
